// ### hdl/cts_charger_control.sv
// Charger thermal zone, step charge and presence check control with Avalon-MM registers
// Summary of operation
// RULE1: Classify battery into one of five zones
// RULE2: Sample thermistor only while monitoring enabled
// RULE3: Cold, hot or no thermistor always inhibit
// RULE4: Cool, room, warm follow zone control field
// RULE5: Per-zone 2-bit select reduces regulation voltage
// RULE6: Per-zone select reduces fast-charge current
// RULE7: Zone control can inhibit cool and warm
// RULE8: Above step threshold, reduce fast-charge current
// RULE9: Step current is programmed percent of full
// RULE10: Step decision uses programmed voltage hysteresis
// RULE11: Step code 111 disables step reduction
// RULE12: Apply lower of zone and step currents
// RULE13: Charger state readable in status field
// RULE14: Pull-down control; battery good from undervoltage
// RULE15: Forced precharge with enable in one write
// RULE16: Regulation reached when battery at regulation
// RULE17: Host checks battery good using pull-down
// RULE18: Host treats regulation reached as absent
// RULE19: Interrupt low while unmasked flag; read clears
// RULE20: Step released below threshold minus hysteresis
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module cts_charger_control (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [7:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [3:0] i_byteenable,
   input wire logic [31:0] i_writedata,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   input wire logic [cts_pkg::CTS_PIN_W-1:0] i_pins,
   input wire logic [7:0] i_vbat_code,
   output logic o_thermistor_pullup_supply,
   output logic o_battery_pulldown_enable,
   output cts_pkg::cts_drive_t o_drive,
   output logic o_int_n
);
   import cts_pkg::*;

   // Byte-lane merge for a write
   function automatic logic [31:0] cts_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : cts_merge

   // Step current percent from 3-bit code; code 7 gives full current
   function automatic logic [6:0] cts_step_pct(input logic [2:0] code);
      logic [6:0] p;
      p = CTS_PCT_STEP_BASE;
      for (int k = 0; k < 7; k++) begin
         if (k < int'(code)) begin
            p = p + CTS_PCT_STEP_INC;
         end
      end
      return p;
   endfunction : cts_step_pct

   // Three-stage synchroniser; value changes once stages two and three agree
   logic [CTS_PIN_W-1:0] sync1_reg;
   logic [CTS_PIN_W-1:0] sync2_reg;
   logic [CTS_PIN_W-1:0] sync3_reg;
   logic [CTS_PIN_W-1:0] pin_reg;

   genvar g;
   generate
      for (g = 0; g < CTS_PIN_W; g++) begin : g_sync
         always_ff @(posedge i_mclk or negedge i_nrst) begin
            if (!i_nrst) begin
               sync1_reg[g] <= 1'b0;
               sync2_reg[g] <= 1'b0;
               sync3_reg[g] <= 1'b0;
               pin_reg[g] <= 1'b0;
            end else begin
               sync1_reg[g] <= i_pins[g];
               sync2_reg[g] <= sync1_reg[g];
               sync3_reg[g] <= sync2_reg[g];
               if (sync2_reg[g] == sync3_reg[g]) begin
                  pin_reg[g] <= sync3_reg[g];
               end
            end
         end
      end
   endgenerate

   // Configuration
   logic [3:0] ctrl_reg;
   logic frc_active_reg;
   logic [10:0] zone_cfg_reg;

   // Step settings
   logic [7:0] step_rise_reg;
   logic [2:0] step_pct_reg;
   logic [3:0] step_hys_reg;

   // Interrupts
   logic [CTS_INT_W-1:0] int_flag_reg;
   logic [CTS_INT_W-1:0] int_mask_reg;

   // Bus answer
   logic ack_reg;
   logic [31:0] rdata_reg;

   // Zone and state
   cts_zone_t zone_reg;
   cts_zone_t zone_next;
   cts_state_t state_reg;
   cts_state_t state_next;

   // Status and drive
   logic step_act_reg;
   logic step_act_next;
   logic bat_good_reg;
   logic in_valid_reg;
   cts_drive_t drive_reg;
   cts_drive_t drive_next;

   // Bus decode: one wait cycle, then the access completes
   wire req = i_read | i_write;
   wire accept = req & ack_reg;

   // Writes land at the answer edge
   wire wr_ctrl = accept & i_write & (i_address == CTS_OFS_CTRL);
   wire wr_zone = accept & i_write & (i_address == CTS_OFS_ZONE);
   wire wr_step = accept & i_write & (i_address == CTS_OFS_STEP);
   wire wr_imsk = accept & i_write & (i_address == CTS_OFS_IMSK);
   wire rd_iflg = accept & i_read & (i_address == CTS_OFS_IFLG);
   assign o_waitrequest = req & ~ack_reg;

   wire [31:0] ctrl_new = cts_merge({28'h0000000, ctrl_reg}, i_writedata, i_byteenable);
   wire [31:0] zone_new = cts_merge({21'h000000, zone_cfg_reg}, i_writedata, i_byteenable);
   wire [31:0] step_new = cts_merge({16'h0000, step_hys_reg, 1'b0, step_pct_reg, step_rise_reg},
                                    i_writedata, i_byteenable);
   wire [31:0] imsk_new = cts_merge({28'h0000000, int_mask_reg}, i_writedata, i_byteenable);

   wire chg_en = ctrl_reg[CTS_CTRL_CHG_EN];
   wire thm_en = ctrl_reg[CTS_CTRL_THM_EN];
   wire [1:0] zone_ctl = zone_cfg_reg[CTS_ZONE_CTL_LSB +: 2];

   // Zone classification from synchronised comparator outputs
   wire thm_open = pin_reg[CTS_PIN_THM_OPEN];

   always_comb begin
      zone_next = zone_reg;
      if (!thm_en) begin
         zone_next = CTS_Z_OFF; // RULE2
      end else if (thm_open) begin
         zone_next = CTS_Z_ABSENT;
      end else if (pin_reg[CTS_PIN_COLD]) begin
         zone_next = CTS_Z_COLD; // RULE1
      end else if (pin_reg[CTS_PIN_HOT]) begin
         zone_next = CTS_Z_HOT;
      end else if (pin_reg[CTS_PIN_COOL]) begin
         zone_next = CTS_Z_COOL;
      end else if (pin_reg[CTS_PIN_WARM]) begin
         zone_next = CTS_Z_WARM;
      end else begin
         zone_next = CTS_Z_ROOM;
      end
   end

   // Zone effects; bit 0 of zone control applies the per-zone selects
   wire in_cool = (zone_reg == CTS_Z_COOL);
   wire in_room = (zone_reg == CTS_Z_ROOM);
   wire in_warm = (zone_reg == CTS_Z_WARM);
   wire hard_inhibit = (zone_reg == CTS_Z_COLD) | (zone_reg == CTS_Z_HOT)
                       | (zone_reg == CTS_Z_ABSENT); // RULE3
   wire soft_inhibit = zone_ctl[1] & (in_cool | in_warm); // RULE7
   wire zone_inhibit = hard_inhibit | soft_inhibit;

   // Bit 0 of each voltage select acts
   wire vreg_sel = (in_cool & zone_cfg_reg[CTS_ZONE_COOL_V_LSB])
                   | (in_room & zone_cfg_reg[CTS_ZONE_ROOM_V_LSB])
                   | (in_warm & zone_cfg_reg[CTS_ZONE_WARM_V_LSB]); // RULE5
   wire cur_sel = (in_cool & zone_cfg_reg[CTS_ZONE_COOL_I])
                  | (in_room & zone_cfg_reg[CTS_ZONE_ROOM_I])
                  | (in_warm & zone_cfg_reg[CTS_ZONE_WARM_I]); // RULE6

   wire zone_vreg_red = zone_ctl[0] & vreg_sel; // RULE4
   wire zone_cur_red = zone_ctl[0] & cur_sel; // RULE4

   // Step charge with hysteresis; release point saturates at zero
   wire [7:0] step_fall = (step_rise_reg > {4'h0, step_hys_reg})
                          ? step_rise_reg - {4'h0, step_hys_reg} : 8'h00;

   // Equal to the threshold keeps the decision
   always_comb begin
      step_act_next = step_act_reg;
      if (step_pct_reg == CTS_STEP_OFF_CODE) begin
         step_act_next = 1'b0; // RULE11
      end else if (i_vbat_code > step_rise_reg) begin
         step_act_next = 1'b1; // RULE8
      end else if (i_vbat_code < step_fall) begin
         step_act_next = 1'b0; // RULE10 RULE20
      end
   end

   // Lower of the two reductions wins
   wire [6:0] step_cur = step_act_reg ? cts_step_pct(step_pct_reg) : CTS_PCT_FULL; // RULE9
   wire [6:0] zone_cur = zone_cur_red ? CTS_PCT_ZONE : CTS_PCT_FULL;
   wire [6:0] min_cur = (step_cur < zone_cur) ? step_cur : zone_cur; // RULE12

   // Charger state machine
   wire at_reg = pin_reg[CTS_PIN_AT_REG];

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         CTS_ST_IDLE, CTS_ST_PCHG, CTS_ST_FAST, CTS_ST_MAINT, CTS_ST_INHIBIT: begin
            if (!chg_en) begin
               state_next = CTS_ST_IDLE;
            end else if (zone_inhibit) begin
               state_next = CTS_ST_INHIBIT; // RULE3
            end else if (frc_active_reg | pin_reg[CTS_PIN_LOW_PCHG]) begin
               state_next = CTS_ST_PCHG; // RULE15
            end else if (at_reg) begin
               state_next = CTS_ST_MAINT;
            end else begin
               state_next = CTS_ST_FAST;
            end
         end
         default: begin
            state_next = CTS_ST_IDLE;
         end
      endcase
   end

   always_comb begin
      drive_next.charge_on = (state_next == CTS_ST_PCHG) | (state_next == CTS_ST_FAST)
                             | (state_next == CTS_ST_MAINT);
      drive_next.precharge = (state_next == CTS_ST_PCHG);
      drive_next.vreg_reduced = zone_vreg_red;
      drive_next.current_pct = min_cur;
   end

   // Status word and read mux
   wire [31:0] stat_word = {23'h000000, step_act_reg, zone_reg, at_reg, bat_good_reg,
                            state_reg}; // RULE13 RULE16
   wire [31:0] rd_mux = (i_address == CTS_OFS_CTRL) ? {28'h0000000, ctrl_reg}
                      : (i_address == CTS_OFS_ZONE) ? {21'h000000, zone_cfg_reg}
                      : (i_address == CTS_OFS_STEP) ? {16'h0000, step_hys_reg, 1'b0,
                                                       step_pct_reg, step_rise_reg}
                      : (i_address == CTS_OFS_STAT) ? stat_word
                      : (i_address == CTS_OFS_IFLG) ? {28'h0000000, int_flag_reg}
                      : (i_address == CTS_OFS_IMSK) ? {28'h0000000, int_mask_reg}
                      : 32'h00000000;

   // Interrupt events; a new event beats a clear-on-read in the same cycle
   wire bat_good_now = ~pin_reg[CTS_PIN_UVLO]; // RULE14
   wire [CTS_INT_W-1:0] int_evt = {(bat_good_now != bat_good_reg),
                                   (state_next != state_reg),
                                   (zone_next != zone_reg),
                                   (pin_reg[CTS_PIN_IN_VALID] & ~in_valid_reg)};
   // Clear only the flags that the read returned
   wire [CTS_INT_W-1:0] int_clr = rd_iflg ? rdata_reg[CTS_INT_W-1:0] : 4'h0;
   wire [CTS_INT_W-1:0] int_next = int_evt | (int_flag_reg & ~int_clr); // RULE19

   // Bus handshake and read data
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else begin
         ack_reg <= req & ~ack_reg;
         if (req & ~ack_reg) begin
            rdata_reg <= rd_mux;
         end
      end
   end
   assign o_readdata = rdata_reg;

   // Host-written configuration
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_reg <= CTS_RST_CTRL;
         frc_active_reg <= 1'b0;
         zone_cfg_reg <= CTS_RST_ZONE;
         step_rise_reg <= CTS_RST_RISE;
         step_pct_reg <= CTS_RST_PCT;
         step_hys_reg <= CTS_RST_HYS;
         int_mask_reg <= CTS_RST_IMSK;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= ctrl_new[3:0];
            // Forcing needs both bits in one access; dropping either ends it
            frc_active_reg <= ctrl_new[CTS_CTRL_FRC_PCHG] & ctrl_new[CTS_CTRL_CHG_EN]
                              & (frc_active_reg | i_writedata[CTS_CTRL_FRC_PCHG]); // RULE15
         end

         if (wr_zone) begin
            zone_cfg_reg <= zone_new[10:0];
         end

         if (wr_step) begin
            step_rise_reg <= step_new[CTS_STEP_RISE_LSB +: 8];
            step_pct_reg <= step_new[CTS_STEP_PCT_LSB +: 3];
            step_hys_reg <= step_new[CTS_STEP_HYS_LSB +: 4];
         end

         if (wr_imsk) begin
            int_mask_reg <= imsk_new[CTS_INT_W-1:0];
         end
      end
   end

   // Block state
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         zone_reg <= CTS_Z_OFF;
         state_reg <= CTS_ST_IDLE;
         step_act_reg <= 1'b0;
         bat_good_reg <= 1'b0;
         in_valid_reg <= 1'b0;
         int_flag_reg <= 4'h0;
         drive_reg <= '0;
      end else begin
         zone_reg <= zone_next;
         state_reg <= state_next;
         step_act_reg <= step_act_next;
         bat_good_reg <= bat_good_now;
         in_valid_reg <= pin_reg[CTS_PIN_IN_VALID];
         int_flag_reg <= int_next;
         drive_reg <= drive_next;
      end
   end

   // Pull-up supply powers the divider only while monitoring is on
   assign o_thermistor_pullup_supply = thm_en; // RULE2
   assign o_battery_pulldown_enable = ctrl_reg[CTS_CTRL_PULLDOWN]; // RULE14
   assign o_drive = drive_reg;

   assign o_int_n = ~|(int_flag_reg & int_mask_reg); // RULE19

endmodule : cts_charger_control

// ### hdl/cts_pkg.sv
// Constants, types and register map of the charger thermal and step control block
package cts_pkg;

   // Register byte addresses (word aligned)
   localparam logic [7:0] CTS_OFS_CTRL = 8'h00;
   localparam logic [7:0] CTS_OFS_ZONE = 8'h04;
   localparam logic [7:0] CTS_OFS_STEP = 8'h08;
   localparam logic [7:0] CTS_OFS_STAT = 8'h0c;
   localparam logic [7:0] CTS_OFS_IFLG = 8'h10;
   localparam logic [7:0] CTS_OFS_IMSK = 8'h14;

   // Control register bit positions
   localparam int CTS_CTRL_CHG_EN = 0;
   localparam int CTS_CTRL_FRC_PCHG = 1;
   localparam int CTS_CTRL_PULLDOWN = 2;
   localparam int CTS_CTRL_THM_EN = 3;

   // Zone configuration field positions
   localparam int CTS_ZONE_CTL_LSB = 0;
   localparam int CTS_ZONE_COOL_V_LSB = 2;
   localparam int CTS_ZONE_ROOM_V_LSB = 4;
   localparam int CTS_ZONE_WARM_V_LSB = 6;
   localparam int CTS_ZONE_COOL_I = 8;
   localparam int CTS_ZONE_ROOM_I = 9;
   localparam int CTS_ZONE_WARM_I = 10;

   // Step configuration field positions
   localparam int CTS_STEP_RISE_LSB = 0;
   localparam int CTS_STEP_PCT_LSB = 8;
   localparam int CTS_STEP_HYS_LSB = 12;

   // Status register field positions
   localparam int CTS_STAT_STATE_LSB = 0;
   localparam int CTS_STAT_BAT_GOOD = 3;
   localparam int CTS_STAT_REG_DONE = 4;
   localparam int CTS_STAT_ZONE_LSB = 5;
   localparam int CTS_STAT_STEP_ACT = 8;

   // Interrupt flag positions
   localparam int CTS_INT_INPUT_VALID = 0;
   localparam int CTS_INT_ZONE = 1;
   localparam int CTS_INT_STATE = 2;
   localparam int CTS_INT_BAT_GOOD = 3;
   localparam int CTS_INT_W = 4;

   // Reset values
   localparam logic [3:0] CTS_RST_CTRL = 4'h0;
   localparam logic [10:0] CTS_RST_ZONE = 11'h000;
   localparam logic [7:0] CTS_RST_RISE = 8'hff;
   localparam logic [2:0] CTS_RST_PCT = 3'h7;
   localparam logic [3:0] CTS_RST_HYS = 4'h2;
   localparam logic [3:0] CTS_RST_IMSK = 4'h0;

   // Current levels in percent of full fast-charge current
   localparam logic [6:0] CTS_PCT_FULL = 7'h64;
   localparam logic [6:0] CTS_PCT_ZONE = 7'h32;
   localparam logic [6:0] CTS_PCT_STEP_BASE = 7'h1e;
   localparam logic [6:0] CTS_PCT_STEP_INC = 7'h0a;
   localparam logic [2:0] CTS_STEP_OFF_CODE = 3'h7;

   // Pin input vector positions
   localparam int CTS_PIN_THM_OPEN = 0;
   localparam int CTS_PIN_COLD = 1;
   localparam int CTS_PIN_COOL = 2;
   localparam int CTS_PIN_WARM = 3;
   localparam int CTS_PIN_HOT = 4;
   localparam int CTS_PIN_UVLO = 5;
   localparam int CTS_PIN_AT_REG = 6;
   localparam int CTS_PIN_LOW_PCHG = 7;
   localparam int CTS_PIN_IN_VALID = 8;
   localparam int CTS_PIN_W = 9;

   typedef enum logic [2:0] {
      CTS_ST_IDLE = 3'b000,
      CTS_ST_PCHG = 3'b001,
      CTS_ST_FAST = 3'b011,
      CTS_ST_MAINT = 3'b010,
      CTS_ST_INHIBIT = 3'b110
   } cts_state_t;

   typedef enum logic [2:0] {
      CTS_Z_OFF = 3'h0,
      CTS_Z_COLD = 3'h1,
      CTS_Z_COOL = 3'h2,
      CTS_Z_ROOM = 3'h3,
      CTS_Z_WARM = 3'h4,
      CTS_Z_HOT = 3'h5,
      CTS_Z_ABSENT = 3'h6
   } cts_zone_t;

   // Charger actuation outputs toward the analog charger
   typedef struct packed {
      logic charge_on;
      logic precharge;
      logic vreg_reduced;
      logic [6:0] current_pct;
   } cts_drive_t;

endpackage : cts_pkg

// ### bench/cts_charger_control_assertions.sv
// Port checker for the charger thermal and step control block
`timescale 1ns/100ps
module cts_charger_control_assertions
   import cts_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [7:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [3:0] i_byteenable,
   input wire logic [31:0] i_writedata,
   input wire logic [31:0] o_readdata,
   input wire logic o_waitrequest,
   input wire logic [cts_pkg::CTS_PIN_W-1:0] i_pins,
   input wire logic [7:0] i_vbat_code,
   input wire logic o_thermistor_pullup_supply,
   input wire logic o_battery_pulldown_enable,
   input wire cts_pkg::cts_drive_t o_drive,
   input wire logic o_int_n
);
   import cts_pkg::*;
   logic [3:0] cold_cnt_reg;
   wire req = i_read | i_write;
   wire done = req & ~o_waitrequest;
   wire ctrl_wr = done & i_write & (i_address == CTS_OFS_CTRL) & i_byteenable[0];
   wire msk_wr = done & i_write & (i_address == CTS_OFS_IMSK) & i_byteenable[0];
   wire cold_seen = i_pins[CTS_PIN_COLD] & o_thermistor_pullup_supply;
   // Saturating count: pins need several edges to reach the drive outputs
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) cold_cnt_reg <= 4'h0;
      else if (!cold_seen) cold_cnt_reg <= 4'h0;
      else if (cold_cnt_reg != 4'hf) cold_cnt_reg <= cold_cnt_reg + 4'h1;
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   sequence s_force_wr;
      ctrl_wr && (i_writedata[3:0] == 4'h3);
   endsequence
   sequence s_pchg_on;
      ##[1:3] (o_drive.charge_on && o_drive.precharge);
   endsequence
   a_wait_one: assert property (req && o_waitrequest |=> !o_waitrequest)
      else $error("request not answered after one wait cycle");
   a_unmapped_zero: assert property (done && i_read && (i_address == 8'h18) |-> o_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_pullup_write: assert property (ctrl_wr |=> o_thermistor_pullup_supply == $past(i_writedata[3]))
      else $error("monitor supply does not follow control write");
   a_pulldown_write: assert property (ctrl_wr |=> o_battery_pulldown_enable == $past(i_writedata[2]))
      else $error("pulldown does not follow control write");
   a_force_pchg: assert property (s_force_wr |-> s_pchg_on)
      else $error("forced precharge not entered");
   a_disable_off: assert property (ctrl_wr && !i_writedata[0] |-> ##[1:3] !o_drive.charge_on)
      else $error("charger still on after disable");
   a_cold_inhibit: assert property (cold_cnt_reg == 4'h8 |-> !o_drive.charge_on)
      else $error("charging in cold zone");
   a_pct_range: assert property (o_drive.charge_on |-> (o_drive.current_pct <= CTS_PCT_FULL)
      && (o_drive.current_pct >= CTS_PCT_STEP_BASE))
      else $error("current percent out of range");
   a_mask_clear: assert property (msk_wr && (i_writedata[3:0] == 4'h0) |=> o_int_n)
      else $error("interrupt low with all flags masked");
endmodule : cts_charger_control_assertions

bind cts_charger_control cts_charger_control_assertions u_cts_charger_control_assertions (
   .i_mclk(i_mclk), .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read),
   .i_write(i_write), .i_byteenable(i_byteenable), .i_writedata(i_writedata),
   .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_pins(i_pins),
   .i_vbat_code(i_vbat_code), .o_thermistor_pullup_supply(o_thermistor_pullup_supply),
   .o_battery_pulldown_enable(o_battery_pulldown_enable), .o_drive(o_drive), .o_int_n(o_int_n));

// ### bench/cts_pack_model.sv
// Battery pack, thermistor and input supply model behind the comparator pins
`timescale 1ns/100ps
module cts_pack_model
   import cts_pkg::*;
#(
   parameter int DISCHARGE_CYCLES = 20
)(
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire cts_pkg::cts_zone_t i_temp,
   input wire logic i_present,
   input wire logic i_usb_ok,
   input wire logic i_pulldown,
   input wire cts_pkg::cts_drive_t i_drive,
   output logic [cts_pkg::CTS_PIN_W-1:0] o_pins
);
   import cts_pkg::*;
   int pd_cnt_reg;
   // An absent pack keeps its node charged until the pulldown drains it
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) pd_cnt_reg <= 0;
      else if (i_drive.charge_on) pd_cnt_reg <= 0;
      else if (i_pulldown && pd_cnt_reg < DISCHARGE_CYCLES) pd_cnt_reg <= pd_cnt_reg + 1;
   end
   wire uvlo = !i_present && (pd_cnt_reg >= DISCHARGE_CYCLES);
   // Colder than cold is also colder than cool, so both comparators trip
   assign o_pins[CTS_PIN_THM_OPEN] = (i_temp == CTS_Z_ABSENT);
   assign o_pins[CTS_PIN_COLD] = (i_temp == CTS_Z_COLD);
   assign o_pins[CTS_PIN_COOL] = (i_temp == CTS_Z_COLD) || (i_temp == CTS_Z_COOL);
   assign o_pins[CTS_PIN_WARM] = (i_temp == CTS_Z_WARM) || (i_temp == CTS_Z_HOT);
   assign o_pins[CTS_PIN_HOT] = (i_temp == CTS_Z_HOT);
   assign o_pins[CTS_PIN_UVLO] = uvlo;
   assign o_pins[CTS_PIN_AT_REG] = !i_present && i_drive.charge_on;
   assign o_pins[CTS_PIN_LOW_PCHG] = uvlo;
   assign o_pins[CTS_PIN_IN_VALID] = i_usb_ok;
endmodule : cts_pack_model

// ### bench/cts_charger_control_bench.sv
// Self-checking bench of the charger thermal and step control block
`timescale 1ns/100ps
module cts_charger_control_bench;
   import cts_pkg::*;
   logic i_mclk = 1'b0;
   logic i_nrst = 1'b0;
   logic [7:0] i_address = 8'h00;
   logic i_read = 1'b0;
   logic i_write = 1'b0;
   logic [3:0] i_byteenable = 4'hf;
   logic [31:0] i_writedata = 32'h0;
   logic [7:0] i_vbat_code = 8'h60;
   logic [CTS_PIN_W-1:0] i_pins;
   logic [31:0] o_readdata;
   logic o_waitrequest;
   logic o_thermistor_pullup_supply;
   logic o_battery_pulldown_enable;
   logic o_int_n;
   cts_drive_t o_drive;
   cts_zone_t temp = CTS_Z_ROOM;
   logic present = 1'b1;
   logic usb_ok = 1'b0;
   logic [31:0] rd;
   int fails = 0;
   int check_count = 0;
   cts_zone_t zl [6] = '{CTS_Z_COLD, CTS_Z_HOT, CTS_Z_ABSENT, CTS_Z_COOL, CTS_Z_ROOM, CTS_Z_WARM};
   logic [1:0] cl [3] = '{2'h1, 2'h3, 2'h0};
   logic [7:0] vb [5] = '{8'h81, 8'h7d, 8'h7c, 8'h7b, 8'h80};
   logic inh;

   cts_charger_control u_cts_charger_control (.i_mclk(i_mclk), .i_nrst(i_nrst),
      .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_byteenable(i_byteenable),
      .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .i_pins(i_pins), .i_vbat_code(i_vbat_code),
      .o_thermistor_pullup_supply(o_thermistor_pullup_supply),
      .o_battery_pulldown_enable(o_battery_pulldown_enable), .o_drive(o_drive), .o_int_n(o_int_n));
   cts_pack_model u_cts_pack_model (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_temp(temp),
      .i_present(present), .i_usb_ok(usb_ok), .i_pulldown(o_battery_pulldown_enable),
      .i_drive(o_drive), .o_pins(i_pins));

   initial begin
      forever #50 i_mclk = ~i_mclk;
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      @(posedge i_mclk);
      i_address <= addr;
      i_writedata <= data;
      i_write <= wr;
      i_read <= !wr;
      do begin
         @(posedge i_mclk);
      end while (o_waitrequest !== 1'b0);
      rd = o_readdata;
      i_write <= 1'b0;
      i_read <= 1'b0;
      // Let the write land before outputs are looked at
      @(posedge i_mclk);
   endtask : bus

   task automatic settle;
      repeat (8) @(posedge i_mclk);
      bus(1'b0, CTS_OFS_STAT, 32'h0);
   endtask : settle

   initial begin
      repeat (20000) @(posedge i_mclk);
      fails++;
      complete_run;
   end

   initial begin
      repeat (5) @(posedge i_mclk);
      i_nrst <= 1'b1;
      bus(1'b0, CTS_OFS_CTRL, 32'h0);
      check("ctrl", rd, 32'h0);
      bus(1'b0, CTS_OFS_ZONE, 32'h0);
      check("zone cfg", rd, 32'h0);
      bus(1'b0, CTS_OFS_STEP, 32'h0);
      check("step cfg", rd, 32'h27ff);
      bus(1'b1, 8'h18, 32'hffffffff);
      bus(1'b0, 8'h18, 32'h0);
      check("unmapped", rd, 32'h0);
      settle;
      check("state", rd[2:0], CTS_ST_IDLE);
      check("bat good", rd[CTS_STAT_BAT_GOOD], 1'b1);
      $display("test reset done");
      bus(1'b1, CTS_OFS_CTRL, 32'h9);
      for (int p = 0; p < 3; p++) begin
         bus(1'b1, CTS_OFS_ZONE, {30'h101, cl[p]});
         for (int i = 0; i < 6; i++) begin
            temp <= zl[i];
            settle;
            inh = (zl[i] inside {CTS_Z_COLD, CTS_Z_HOT, CTS_Z_ABSENT})
               || (cl[p][1] && (zl[i] inside {CTS_Z_COOL, CTS_Z_WARM}));
            check("zone", rd[7:5], zl[i]);
            check("state", rd[2:0], inh ? CTS_ST_INHIBIT : CTS_ST_FAST);
            check("charge", o_drive.charge_on, !inh);
            if (!inh) begin
               check("vreg", o_drive.vreg_reduced, cl[p][0] && zl[i] == CTS_Z_COOL);
               check("pct", o_drive.current_pct,
                  (cl[p][0] && zl[i] == CTS_Z_WARM) ? CTS_PCT_ZONE : CTS_PCT_FULL);
            end
         end
      end
      bus(1'b1, CTS_OFS_CTRL, 32'h1);
      temp <= CTS_Z_COLD;
      settle;
      check("supply", o_thermistor_pullup_supply, 1'b0);
      check("zone off", rd[7:5], CTS_Z_OFF);
      check("state", rd[2:0], CTS_ST_FAST);
      $display("test zones done");
      bus(1'b1, CTS_OFS_STEP, 32'h4480);
      for (int i = 0; i < 5; i++) begin
         i_vbat_code <= vb[i];
         settle;
         check("step act", rd[CTS_STAT_STEP_ACT], i < 3);
         check("pct", o_drive.current_pct, (i < 3) ? 7'h46 : CTS_PCT_FULL);
      end
      i_vbat_code <= 8'hff;
      bus(1'b1, CTS_OFS_STEP, 32'h4780);
      settle;
      check("step off", o_drive.current_pct, CTS_PCT_FULL);
      bus(1'b1, CTS_OFS_CTRL, 32'h9);
      bus(1'b1, CTS_OFS_ZONE, 32'h401);
      temp <= CTS_Z_WARM;
      bus(1'b1, CTS_OFS_STEP, 32'h4080);
      settle;
      check("min step", o_drive.current_pct, CTS_PCT_STEP_BASE);
      bus(1'b1, CTS_OFS_STEP, 32'h4580);
      settle;
      check("min zone", o_drive.current_pct, CTS_PCT_ZONE);
      $display("test step done");
      bus(1'b1, CTS_OFS_CTRL, 32'h0);
      bus(1'b1, CTS_OFS_IMSK, 32'h0);
      bus(1'b0, CTS_OFS_IFLG, 32'h0);
      usb_ok <= 1'b1;
      settle;
      check("masked", o_int_n, 1'b1);
      bus(1'b1, CTS_OFS_IMSK, 32'h1);
      check("int", o_int_n, 1'b0);
      bus(1'b0, CTS_OFS_IFLG, 32'h0);
      check("flag", rd[CTS_INT_INPUT_VALID], 1'b1);
      @(posedge i_mclk);
      check("int released", o_int_n, 1'b1);
      bus(1'b0, CTS_OFS_IFLG, 32'h0);
      check("flag clear", rd[CTS_INT_INPUT_VALID], 1'b0);
      $display("test interrupt done");
      present <= 1'b0;
      temp <= CTS_Z_ROOM;
      bus(1'b1, CTS_OFS_CTRL, 32'h4);
      check("pulldown", o_battery_pulldown_enable, 1'b1);
      repeat (30) @(posedge i_mclk);
      settle;
      check("bat good", rd[CTS_STAT_BAT_GOOD], 1'b0);
      bus(1'b1, CTS_OFS_CTRL, 32'h0);
      check("pulldown", o_battery_pulldown_enable, 1'b0);
      bus(1'b1, CTS_OFS_CTRL, 32'h3);
      settle;
      check("state", rd[2:0], CTS_ST_PCHG);
      check("reg done", rd[CTS_STAT_REG_DONE], 1'b1);
      check("precharge", o_drive.precharge, 1'b1);
      bus(1'b1, CTS_OFS_CTRL, 32'h1);
      settle;
      check("state", rd[2:0], CTS_ST_MAINT);
      present <= 1'b1;
      bus(1'b1, CTS_OFS_CTRL, 32'h0);
      bus(1'b1, CTS_OFS_CTRL, 32'h3);
      settle;
      check("state", rd[2:0], CTS_ST_PCHG);
      check("reg done", rd[CTS_STAT_REG_DONE], 1'b0);
      check("bat good", rd[CTS_STAT_BAT_GOOD], 1'b1);
      $display("test presence done");
      complete_run;
   end
endmodule : cts_charger_control_bench
